// >>> scr_regs.sv
// Serial word receiver and control bank for power, output, lock detect and band words.
// Assumes host drives serial clock enable, data and load strobe synchronous to clk_i.
`timescale 1ns/1ps
module scr_regs (
   input  wire logic               clk_i,          // System clock, 25 MHz
   input  wire logic               rst_i,          // Async reset, active high
   input  wire logic               sclk_rise_i,    // Serial clock rising edge strobe
   input  wire logic               sdata_i,        // Serial data bit
   input  wire logic               load_strobe_i,  // Load strobe level
   input  wire logic               ref_rise_i,     // Reference input rising edge strobe
   input  wire logic               lock_det_i,     // Digital lock detect from detector
   output logic                    power_down_o,   // Software power-down active
   output logic                    load_pulse_o,   // Divider load pulse
   output logic                    fixed_err_o,    // Last reserved word was not its fixed value
   output scr_pkg::scr_analog_s    analog_o,       // Analog control bundle
   output scr_pkg::scr_lock_s      lock_o          // Lock detector settings bundle
);
   import scr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] shift_reg;
   logic [31:0] r4_reg;
   logic [31:0] r6_reg;
   logic [31:0] r7_reg;
   logic [31:0] r9_reg;
   logic [2:0]  div_act_reg;
   logic        strobe_d_reg;
   logic        sync_pend_reg;
   logic        fixed_err_reg;
   logic        load_pulse_reg;
   logic        power_down_reg;
   scr_analog_s analog_reg;
   scr_lock_s   lock_reg;

   wire         strobe_rise = load_strobe_i & ~strobe_d_reg;
   wire [3:0]   sel_code    = shift_reg[3:0];
   wire         wr_r0  = strobe_rise & (sel_code == SEL_R0);
   wire         wr_r4  = strobe_rise & (sel_code == SEL_R4);
   wire         wr_r6  = strobe_rise & (sel_code == SEL_R6);
   wire         wr_r7  = strobe_rise & (sel_code == SEL_R7);
   wire         wr_r9  = strobe_rise & (sel_code == SEL_R9);
   wire         wr_r5  = strobe_rise & (sel_code == SEL_R5);
   wire         wr_r8  = strobe_rise & (sel_code == SEL_R8);
   // fixed word check, flags host misuse only
   wire         bad_fix = (wr_r5 & (shift_reg != FIXED_FIVE))
                        | (wr_r8 & (shift_reg != FIXED_EIGHT));

   wire [2:0]   new_div  = shift_reg[P6_DIV_HI:P6_DIV_LO];
   wire         dbuf_on  = r4_reg[P4_DBUF];
   wire [2:0]   div_next = (wr_r6 & ~dbuf_on) ? new_div
                         : wr_r0 ? r6_reg[P6_DIV_HI:P6_DIV_LO]
                         : div_act_reg;

   wire         pd   = r4_reg[P4_PD];
   wire         crst = r4_reg[P4_CRST];
   wire         lock_ok = lock_det_i & ~pd;

   // load strobe realigned to reference edge
   wire         sync_on   = r7_reg[P7_SYNC];
   wire         load_now  = sync_on ? (sync_pend_reg & ref_rise_i) : wr_r0;
   // A reference edge in the arming cycle itself must not eat the pending load
   wire         pend_next = sync_on & (wr_r0 | (sync_pend_reg & ~ref_rise_i));

   wire [15:0]  prec_win = (r7_reg[P7_PREC_HI:P7_PREC_LO] == 2'h0) ? WIN_PS_0
                         : (r7_reg[P7_PREC_HI:P7_PREC_LO] == 2'h1) ? WIN_PS_1
                         : (r7_reg[P7_PREC_HI:P7_PREC_LO] == 2'h2) ? WIN_PS_2
                         : WIN_PS_3;

   scr_analog_s analog_next;
   scr_lock_s   lock_next;
   always_comb begin
      // power-down forces loads, tristate, lock reset, stages off
      analog_next.prescale_load  = pd;
      analog_next.pump_tristate  = pd | r4_reg[P4_TRI];
      analog_next.ref_div_reset  = crst;
      analog_next.fb_div_reset   = crst;
      analog_next.band_sel_reset = crst;
      analog_next.lock_det_reset = pd;
      analog_next.fb_from_vco    = r6_reg[P6_FB];
      analog_next.out_div        = div_act_reg;
      analog_next.bleed_on       = ~r6_reg[P6_GATED] | lock_ok;
      analog_next.neg_bleed_on   = r6_reg[P6_NEG];
      analog_next.bleed_level    = r6_reg[P6_BL_HI:P6_BL_LO];
      analog_next.pri_stage_on   = ~pd & r6_reg[P6_PRI_EN] & (~r6_reg[P6_MUTE] | lock_ok);
      analog_next.aux_stage_on   = ~pd & r6_reg[P6_AUX_EN] & (~r6_reg[P6_MUTE] | lock_ok);
      analog_next.pri_power      = r6_reg[P6_PRI_PW_HI:P6_PRI_PW_LO];
      analog_next.aux_power      = r6_reg[P6_AUX_PW_HI:P6_AUX_PW_LO];
      lock_next.lock_count       = r7_reg[P7_CNT_HI:P7_CNT_LO];
      lock_next.loss_of_lock     = r7_reg[P7_LOL];
      lock_next.window_ps        = r7_reg[P7_MODE] ? WIN_PS_INT : prec_win;
      lock_next.load_sync        = sync_on;
      lock_next.band_div         = r9_reg[P9_BD_HI:P9_BD_LO];
   end

   ////////////////////////////////////////////////////////////////////////////
   // MSB first shift; keeps shifting in power-down too
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= RST_WORD;
      end else if (sclk_rise_i) begin
         shift_reg <= {shift_reg[30:0], sdata_i};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r4_reg <= RST_WORD;
         r6_reg <= RST_WORD;
         r7_reg <= RST_WORD;
         r9_reg <= RST_WORD;
      end else begin
         if (wr_r4) r4_reg <= shift_reg;
         if (wr_r6) r6_reg <= shift_reg;
         if (wr_r7) r7_reg <= shift_reg;
         if (wr_r9) r9_reg <= shift_reg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_act_reg    <= 3'h0;
         strobe_d_reg   <= 1'b0;
         sync_pend_reg  <= 1'b0;
         fixed_err_reg  <= 1'b0;
         load_pulse_reg <= 1'b0;
         power_down_reg <= 1'b0;
         analog_reg     <= '0;
         lock_reg       <= '0;
      end else begin
         div_act_reg    <= div_next;
         strobe_d_reg   <= load_strobe_i;
         sync_pend_reg  <= pend_next;
         if (wr_r5 | wr_r8) fixed_err_reg <= bad_fix;
         load_pulse_reg <= load_now & ~pd;
         power_down_reg <= pd;
         analog_reg     <= analog_next;
         lock_reg       <= lock_next;
      end
   end

   assign power_down_o = power_down_reg;
   assign load_pulse_o = load_pulse_reg;
   assign fixed_err_o  = fixed_err_reg;
   assign analog_o     = analog_reg;
   assign lock_o       = lock_reg;

endmodule // scr_regs

// >>> scr_pkg.sv
// Constants, field layouts and carrier types for the synthesizer control word bank.
// Assumes a host shifting 32-bit words MSB first, control code in the low nibble.
// Summary of operation
// - Power-down bit set enters power-down; clear resumes; registers keep contents.
// - Power-down loads counters, three-states pump, resets lock detect, disables outputs.
// - Pump three-state bit set three-states the charge pump output.
// - Counter reset bit holds reference, feedback dividers and band select in reset.
// - Control code routes word: 0110 output, 0111 lock detect, 1001 band division.
// - Gated bleed keeps bleed current off until lock detect is high; negative bleed is not gated.
// - Negative bleed bit turns constant negative bleed on; host uses it fractional only.
// - Feedback select picks oscillator directly or the output divider chain.
// - Divider select applies at once, or on register zero write when double buffered.
// - Eight-bit bleed level field; host disables bleed above 100 MHz.
// - Mute-until-lock cuts output stage supply until lock detect reports lock.
// - Auxiliary and primary outputs follow their own enable bits.
// - Two-bit fields select auxiliary and primary output power levels.
// - Load sync realigns load strobe to next reference rising edge before loading.
// - Lock count field sets consecutive in-window cycles needed before lock.
// - Loss-of-lock mode also detects reference removal.
// - Precision field selects lock window 5.0, 6.0, 8.0 or 12.0 ns.
// - Window mode bit set fixes the lock window at 2.9 ns.
// - Band division bits 13:9 all ones; bits 31:24 set band clock divider.
package scr_pkg;

   localparam int          WORD_W        = 32;
   localparam logic [3:0]  SEL_R0        = 4'h0;
   localparam logic [3:0]  SEL_R4        = 4'h4;
   localparam logic [3:0]  SEL_R5        = 4'h5;
   localparam logic [3:0]  SEL_R6        = 4'h6;
   localparam logic [3:0]  SEL_R7        = 4'h7;
   localparam logic [3:0]  SEL_R8        = 4'h8;
   localparam logic [3:0]  SEL_R9        = 4'h9;

   // Power and pump control word
   localparam int          P4_DBUF       = 14;
   localparam int          P4_PD         = 6;
   localparam int          P4_TRI        = 5;
   localparam int          P4_CRST       = 4;
   // Output and feedback control word
   localparam int          P6_GATED      = 30;
   localparam int          P6_NEG        = 29;
   localparam int          P6_FB         = 24;
   localparam int          P6_DIV_HI     = 23;
   localparam int          P6_DIV_LO     = 21;
   localparam int          P6_BL_HI      = 20;
   localparam int          P6_BL_LO      = 13;
   localparam int          P6_MUTE       = 11;
   localparam int          P6_AUX_EN     = 9;
   localparam int          P6_AUX_PW_HI  = 8;
   localparam int          P6_AUX_PW_LO  = 7;
   localparam int          P6_PRI_EN     = 6;
   localparam int          P6_PRI_PW_HI  = 5;
   localparam int          P6_PRI_PW_LO  = 4;
   // Lock detect word
   localparam int          P7_SYNC       = 25;
   localparam int          P7_CNT_HI     = 9;
   localparam int          P7_CNT_LO     = 8;
   localparam int          P7_LOL        = 7;
   localparam int          P7_PREC_HI    = 6;
   localparam int          P7_PREC_LO    = 5;
   localparam int          P7_MODE       = 4;
   // Band division word
   localparam int          P9_BD_HI      = 31;
   localparam int          P9_BD_LO      = 24;

   localparam logic [31:0] FIXED_FIVE    = 32'h00800005;
   localparam logic [31:0] FIXED_EIGHT   = 32'h1A69A6B8;
   localparam logic [31:0] RST_WORD      = 32'h00000000;

   // Lock windows in picoseconds, as an encoded output
   localparam logic [15:0] WIN_PS_0      = 16'h1388;
   localparam logic [15:0] WIN_PS_1      = 16'h1770;
   localparam logic [15:0] WIN_PS_2      = 16'h1F40;
   localparam logic [15:0] WIN_PS_3      = 16'h2EE0;
   localparam logic [15:0] WIN_PS_INT    = 16'h0B54;

   typedef struct packed {
      logic       prescale_load;
      logic       pump_tristate;
      logic       ref_div_reset;
      logic       fb_div_reset;
      logic       band_sel_reset;
      logic       lock_det_reset;
      logic       fb_from_vco;
      logic [2:0] out_div;
      logic       bleed_on;
      logic       neg_bleed_on;
      logic [7:0] bleed_level;
      logic       pri_stage_on;
      logic       aux_stage_on;
      logic [1:0] pri_power;
      logic [1:0] aux_power;
   } scr_analog_s;

   typedef struct packed {
      logic [1:0]  lock_count;
      logic        loss_of_lock;
      logic [15:0] window_ps;
      logic        load_sync;
      logic [7:0]  band_div;
   } scr_lock_s;

endpackage

// >>> scr_props.sv
// Checker for the control word bank, watching the top ports only.
// Assumes words arrive MSB first and show at the outputs two edges after the strobe rises.
`timescale 1ns/1ps
module scr_props
   import scr_pkg::*;
(
   input  wire logic                 clk_i,          // Clock
   input  wire logic                 rst_i,          // Async reset
   input  wire logic                 sclk_rise_i,    // Shift strobe
   input  wire logic                 sdata_i,        // Serial data
   input  wire logic                 load_strobe_i,  // Load strobe
   input  wire logic                 power_down_o,   // Power-down level
   input  wire logic                 fixed_err_o,    // Fixed word error
   input  wire scr_pkg::scr_analog_s analog_o,       // Analog bundle
   input  wire scr_pkg::scr_lock_s   lock_o          // Lock bundle
);
   logic [31:0] sh_reg;
   logic [31:0] wd_reg;
   logic        st_reg;
   wire         hit  = load_strobe_i && !st_reg;
   wire  [3:0]  code = sh_reg[3:0];
   // Shadow of the shifter so every check ties an output to the word sent
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sh_reg <= 32'h0;
         wd_reg <= 32'h0;
         st_reg <= 1'b0;
      end else begin
         if (sclk_rise_i) sh_reg <= {sh_reg[30:0], sdata_i};
         if (hit) wd_reg <= sh_reg;
         st_reg <= load_strobe_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   pd_follow_a: assert property (
      hit && code == SEL_R4 |-> ##2 power_down_o == wd_reg[P4_PD]) else $error("pd bit lost");
   pd_effect_a: assert property (
      hit && code == SEL_R4 && sh_reg[P4_PD] |-> ##2 analog_o.pump_tristate
      && analog_o.prescale_load && analog_o.lock_det_reset
      && !analog_o.pri_stage_on && !analog_o.aux_stage_on) else $error("pd effects missing");
   pump_tri_a: assert property (
      hit && code == SEL_R4 |-> ##2 analog_o.pump_tristate == (wd_reg[P4_TRI] | wd_reg[P4_PD]))
      else $error("pump state wrong");
   cnt_reset_a: assert property (
      hit && code == SEL_R4 && !sh_reg[P4_PD] |-> ##2 {analog_o.ref_div_reset,
      analog_o.fb_div_reset, analog_o.band_sel_reset} == {3{wd_reg[P4_CRST]}})
      else $error("counter reset wrong");
   fb_bleed_a: assert property (
      hit && code == SEL_R6 |-> ##2 analog_o.fb_from_vco == wd_reg[P6_FB]
      && analog_o.bleed_level == wd_reg[20:13] && analog_o.neg_bleed_on == wd_reg[P6_NEG])
      else $error("feedback or bleed wrong");
   out_power_a: assert property (
      hit && code == SEL_R6 |-> ##2 {analog_o.aux_power, analog_o.pri_power}
      == {wd_reg[8:7], wd_reg[5:4]}) else $error("power level wrong");
   lock_cfg_a: assert property (
      hit && code == SEL_R7 |-> ##2 lock_o.lock_count == wd_reg[9:8] && lock_o.loss_of_lock
      == wd_reg[P7_LOL] && lock_o.load_sync == wd_reg[P7_SYNC]) else $error("lock cfg wrong");
   band_div_a: assert property (
      hit && code == SEL_R9 |-> ##2 lock_o.band_div == wd_reg[31:24]) else $error("band div wrong");
   fixed_chk_a: assert property (
      hit && code == SEL_R5 |-> ##2 fixed_err_o == (wd_reg != FIXED_FIVE))
      else $error("fixed word flag wrong");
endmodule // scr_props

// >>> scr_host.sv
// Host model: shifts 32-bit words MSB first, then pulses the load strobe.
// Assumes send() is entered just after a rising clock edge.
`timescale 1ns/1ps
module scr_host (
   input  wire logic clk_i,     // System clock
   output logic      sclk_o,    // Shift strobe
   output logic      sdat_o,    // Serial data
   output logic      strobe_o   // Load strobe
);
   initial begin
      sclk_o   = 1'b0;
      sdat_o   = 1'b0;
      strobe_o = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         sclk_o = 1'b1;
         sdat_o = w[i];
         @(posedge clk_i) #1;
      end
      sclk_o   = 1'b0;
      // Idle data shows the inverse so a stale bit never passes
      sdat_o   = ~w[0];
      strobe_o = 1'b1;
      @(posedge clk_i) #1;
      strobe_o = 1'b0;
      @(posedge clk_i) #1;
   endtask
endmodule // scr_host

// >>> testbench.sv
// Testbench for the control word bank: word writes through the host model.
// Assumes outputs settle two edges after the strobe is sampled.
`timescale 1ns/1ps
module testbench;
   import scr_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ref_rise_i = 1'b0;
   logic        lock_det_i = 1'b0;
   logic        sclk, sdat, strobe, power_down_o, load_pulse_o, fixed_err_o;
   scr_analog_s analog_o;
   scr_lock_s   lock_o;
   logic [15:0] win [5] = '{WIN_PS_0, WIN_PS_1, WIN_PS_2, WIN_PS_3, WIN_PS_INT};
   int          bad_count = 0;
   int          n_checks = 0;
   int          n_loads = 0;
   int          base_loads = 0;
   always #20 clk_i = ~clk_i;
   // Load pulses stand one cycle only, so count them at the settled half period
   always @(negedge clk_i) if (load_pulse_o === 1'b1) n_loads++;
   scr_host host_inst (.clk_i(clk_i), .sclk_o(sclk), .sdat_o(sdat), .strobe_o(strobe));
   scr_regs scr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_rise_i(sclk), .sdata_i(sdat),
      .load_strobe_i(strobe), .ref_rise_i(ref_rise_i), .lock_det_i(lock_det_i),
      .power_down_o(power_down_o), .load_pulse_o(load_pulse_o), .fixed_err_o(fixed_err_o),
      .analog_o(analog_o), .lock_o(lock_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [31:0] w);
      host_inst.send(w);
      @(posedge clk_i) #1;
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_pulse();
      for (int k = 0; k < 4 && n_loads == base_loads; k++) @(posedge clk_i) #1;
      chk(n_loads - base_loads, 1);
   endtask
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      #1 rst_i = 1'b0;
      @(posedge clk_i) #1;
      chk(power_down_o, 1'b0);
      put(32'h35B4A376);
      chk({analog_o.fb_from_vco, analog_o.out_div, analog_o.neg_bleed_on}, 5'h1B);
      chk(analog_o.bleed_level, 8'hA5);
      chk({analog_o.aux_power, analog_o.pri_power}, 4'hB);
      chk({analog_o.aux_stage_on, analog_o.pri_stage_on, analog_o.bleed_on}, 3'h7);
      put(32'h75B4AB76);
      chk({analog_o.pri_stage_on, analog_o.bleed_on}, 2'h0);
      lock_det_i = 1'b1;
      repeat (3) @(posedge clk_i) #1;
      chk({analog_o.pri_stage_on, analog_o.bleed_on}, 2'h3);
      // Code 3 belongs to no register of this bank
      put(32'h00000003);
      chk(analog_o.bleed_level, 8'hA5);
      put(32'h00000044);
      chk(power_down_o, 1'b1);
      chk({analog_o.prescale_load, analog_o.pump_tristate, analog_o.lock_det_reset,
         analog_o.pri_stage_on, analog_o.aux_stage_on}, 5'h1C);
      // Lock words keep loading while powered down
      for (int i = 0; i < 5; i++) begin
         put(32'h10000007 | {22'h0, i[1:0], i[0], i[1:0], i[2], 4'h0});
         chk({lock_o.lock_count, lock_o.loss_of_lock}, {i[1:0], i[0]});
         chk(lock_o.window_ps, win[i]);
      end
      put(32'h00000034);
      chk({power_down_o, analog_o.pump_tristate, analog_o.pri_stage_on}, 3'h3);
      chk({analog_o.ref_div_reset, analog_o.fb_div_reset, analog_o.band_sel_reset}, 3'h7);
      chk(lock_o.window_ps, WIN_PS_INT);
      put(32'hC3003E09);
      chk(lock_o.band_div, 8'hC3);
      put(FIXED_FIVE);
      chk(fixed_err_o, 1'b0);
      put(32'h1A69A6F8);
      chk(fixed_err_o, 1'b1);
      put(FIXED_EIGHT);
      chk(fixed_err_o, 1'b0);
      put(32'h00004004);
      put(32'h3594A376);
      chk(analog_o.out_div, 3'h5);
      base_loads = n_loads;
      put(32'h00000000);
      wait_pulse();
      chk(analog_o.out_div, 3'h4);
      put(32'h12000007);
      base_loads = n_loads;
      put(32'h00000000);
      repeat (4) begin
         chk(n_loads, base_loads);
         @(posedge clk_i) #1;
      end
      ref_rise_i = 1'b1;
      @(posedge clk_i) #1;
      ref_rise_i = 1'b0;
      wait_pulse();
      conclude();
   end
endmodule // testbench
bind scr_regs scr_props scr_props_inst (.clk_i(clk_i), .rst_i(rst_i),
   .sclk_rise_i(sclk_rise_i), .sdata_i(sdata_i), .load_strobe_i(load_strobe_i),
   .power_down_o(power_down_o), .fixed_err_o(fixed_err_o), .analog_o(analog_o),
   .lock_o(lock_o));
